// File: hdl/adcrd_cfg.svh
// Constants of the read-triggered converter control block
`ifndef ADCRD_CFG_SVH
`define ADCRD_CFG_SVH
`define ADCRD_OFS_RESULT 4'h0
`define ADCRD_OFS_DIV 4'h4
`define ADCRD_OFS_STATUS 4'h8
`define ADCRD_DONE_BIT 31
`define ADCRD_DIVSEL_BIT 16
`define ADCRD_SIGNED_BIT 0
`define ADCRD_BUSY_BIT 0
`define ADCRD_DIV_SLOW 5'h10
`define ADCRD_DIV_FAST 5'h04
`define ADCRD_CONV_TICKS 5'h10
`define ADCRD_SAMPLE_RST 16'h0000
`define ADCRD_WORD_ZERO 32'h00000000
`define ADCRD_HTRANS_NONSEQ 2'h2
`endif

// File: hdl/adcrd_pkg.sv
// Types of the read-triggered converter control block
`default_nettype none
package adcrd_pkg;
	typedef enum logic [0:0] {
		ADCRD_IDLE = 1'b0,
		ADCRD_BUSY = 1'b1
	} adcrd_state_t;
endpackage
`default_nettype wire

// File: hdl/adcrd_top.sv
// Read-triggered converter control with an AHB-Lite register slave
//
// Contract
// - A read of the result word starts a new conversion when the engine is idle.
// - Every result read returns the sample and a done flag in bit 31.
// - A result read during a conversion leaves that conversion untouched.
// - Bit 16 of the divider register selects the converter clock.
// - Select 0 divides the reference clock by 4, select 1 by 16.
// - The sample sits in bits 15:0; signed mode makes it signed.
`include "adcrd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module adcrd_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ref_clk_in,
	input wire logic [15:0] adc_sample_in,
	output logic adc_busy
);

	//----------------------------------------
	// Helpers
	//----------------------------------------

	// Reference clock edges per converter tick, minus one
	function automatic logic [4:0] div_limit(input logic sel);
		div_limit = sel ? (`ADCRD_DIV_SLOW - 5'h01) : (`ADCRD_DIV_FAST - 5'h01);
	endfunction

	//----------------------------------------
	// Bus decode
	//----------------------------------------

	logic addr_ok;
	logic rd_result;
	logic rd_div;
	logic rd_status;
	logic wr_div_addr;
	logic wr_div_reg;
	logic wr_div_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	// Only NONSEQ transfers are meaningful, whatever their hsize; the rest are ignored
	assign addr_ok = hsel && hready && (htrans == `ADCRD_HTRANS_NONSEQ);
	assign rd_result = addr_ok && !hwrite && (haddr[3:0] == `ADCRD_OFS_RESULT);
	assign rd_div = addr_ok && !hwrite && (haddr[3:0] == `ADCRD_OFS_DIV);
	assign rd_status = addr_ok && !hwrite && (haddr[3:0] == `ADCRD_OFS_STATUS);
	assign wr_div_addr = addr_ok && hwrite && (haddr[3:0] == `ADCRD_OFS_DIV);

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	//----------------------------------------
	// Reference clock synchroniser
	//----------------------------------------

	logic ref_s1_reg;
	logic ref_s2_reg;
	logic ref_s3_reg;
	logic [15:0] samp_s1_reg;
	logic [15:0] samp_s2_reg;
	logic ref_edge;

	// Pin inputs cross two flops; edge detect looks only at later stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
			samp_s1_reg <= `ADCRD_SAMPLE_RST;
			samp_s2_reg <= `ADCRD_SAMPLE_RST;
		end else begin
			ref_s1_reg <= ref_clk_in;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
			samp_s1_reg <= adc_sample_in;
			samp_s2_reg <= samp_s1_reg;
		end
	end

	assign ref_edge = ref_s2_reg && !ref_s3_reg;

	//----------------------------------------
	// Converter clock divider
	//----------------------------------------

	logic div_sel_reg;
	logic div_sel_next;
	logic signed_reg;
	logic signed_next;
	logic [4:0] ref_cnt_reg;
	logic [4:0] ref_cnt_next;
	logic conv_tick;

	// A tick every 4 or 16 reference edges; hclk must be well above ref
	assign conv_tick = ref_edge && (ref_cnt_reg == div_limit(div_sel_reg));

	// Divider register write lands in the data phase
	always_comb begin
		div_sel_next = div_sel_reg;
		signed_next = signed_reg;
		wr_div_next = wr_div_addr;
		ref_cnt_next = ref_cnt_reg;
		if (wr_div_reg) begin
			div_sel_next = hwdata[`ADCRD_DIVSEL_BIT];
			signed_next = hwdata[`ADCRD_SIGNED_BIT];
		end
		if (conv_tick) begin
			ref_cnt_next = 5'h00;
		end else if (ref_edge) begin
			ref_cnt_next = ref_cnt_reg + 5'h01;
		end
		// A shorter divide after a switch must not leave the count past the limit
		if (ref_cnt_next > div_limit(div_sel_reg)) begin
			ref_cnt_next = 5'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_sel_reg <= 1'b0;
			signed_reg <= 1'b0;
			wr_div_reg <= 1'b0;
			ref_cnt_reg <= 5'h00;
		end else begin
			div_sel_reg <= div_sel_next;
			signed_reg <= signed_next;
			wr_div_reg <= wr_div_next;
			ref_cnt_reg <= ref_cnt_next;
		end
	end

	//----------------------------------------
	// Conversion engine
	//----------------------------------------

	adcrd_pkg::adcrd_state_t state_reg;
	adcrd_pkg::adcrd_state_t state_next;
	logic [4:0] conv_cnt_reg;
	logic [4:0] conv_cnt_next;
	logic done_reg;
	logic done_next;
	logic [15:0] sample_reg;
	logic [15:0] sample_next;
	logic conv_start;
	logic conv_finish;

	// Only an idle engine takes a trigger, so a busy read cannot restart it
	assign conv_start = rd_result && (state_reg == adcrd_pkg::ADCRD_IDLE);
	assign conv_finish = (state_reg == adcrd_pkg::ADCRD_BUSY) && conv_tick
		&& (conv_cnt_reg == (`ADCRD_CONV_TICKS - 5'h01));
	assign adc_busy = (state_reg == adcrd_pkg::ADCRD_BUSY);

	// Next state of the engine, its tick count, flag and sample
	always_comb begin
		state_next = state_reg;
		conv_cnt_next = conv_cnt_reg;
		done_next = done_reg;
		sample_next = sample_reg;
		case (state_reg)
			adcrd_pkg::ADCRD_IDLE: begin
				if (conv_start) begin
					state_next = adcrd_pkg::ADCRD_BUSY;
					conv_cnt_next = 5'h00;
					done_next = 1'b0;
				end
			end
			adcrd_pkg::ADCRD_BUSY: begin
				// Reads are not looked at here at all
				if (conv_finish) begin
					state_next = adcrd_pkg::ADCRD_IDLE;
					done_next = 1'b1;
					// Signed mode turns offset binary into two's complement
					sample_next = signed_reg ? {~samp_s2_reg[15], samp_s2_reg[14:0]}
						: samp_s2_reg;
				end else if (conv_tick) begin
					conv_cnt_next = conv_cnt_reg + 5'h01;
				end
			end
			default: begin
				state_next = adcrd_pkg::ADCRD_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= adcrd_pkg::ADCRD_IDLE;
			conv_cnt_reg <= 5'h00;
			done_reg <= 1'b0;
			sample_reg <= `ADCRD_SAMPLE_RST;
		end else begin
			state_reg <= state_next;
			conv_cnt_reg <= conv_cnt_next;
			done_reg <= done_next;
			sample_reg <= sample_next;
		end
	end

	//----------------------------------------
	// Read data
	//----------------------------------------

	// Read word is captured in the address phase, before the trigger clears done
	always_comb begin
		hrdata_next = `ADCRD_WORD_ZERO;
		if (rd_result) begin
			hrdata_next[`ADCRD_DONE_BIT] = done_reg;
			hrdata_next[15:0] = sample_reg;
		end else if (rd_div) begin
			hrdata_next[`ADCRD_DIVSEL_BIT] = div_sel_reg;
			hrdata_next[`ADCRD_SIGNED_BIT] = signed_reg;
		end else if (rd_status) begin
			hrdata_next[`ADCRD_BUSY_BIT] = adc_busy;
			hrdata_next[`ADCRD_DONE_BIT] = done_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= `ADCRD_WORD_ZERO;
		end else begin
			hrdata_reg <= hrdata_next;
		end
	end

	//----------------------------------------
	// Assertions
	//----------------------------------------

	// An idle engine goes busy right after a result read
	a_read_starts: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_result && state_reg == adcrd_pkg::ADCRD_IDLE)
		|=> (state_reg == adcrd_pkg::ADCRD_BUSY) && (conv_cnt_reg == 5'h00))
		else $error("result read did not start a conversion");

	// Bit 31 of the read word shows the done flag seen at the read
	a_done_bit31: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_result |=> (hrdata[`ADCRD_DONE_BIT] == $past(done_reg)))
		else $error("bit 31 does not match the done flag");

	// A busy read neither resets the count nor ends the conversion early
	a_busy_read_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_result && adc_busy && !conv_tick)
		|=> (conv_cnt_reg == $past(conv_cnt_reg)) && adc_busy)
		else $error("read disturbed an ongoing conversion");

	// The divider write data bit 16 becomes the select
	a_div_select: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_div_reg |=> (div_sel_reg == $past(hwdata[`ADCRD_DIVSEL_BIT])))
		else $error("divider select not taken from bit 16");

	// Reference edges since the last tick, counted apart from the divider itself
	logic [4:0] chk_edges_reg;
	logic [4:0] chk_edges_next;
	logic chk_clean_reg;
	logic chk_clean_next;

	// A divider write voids the running interval, since the ratio may change mid-way
	always_comb begin
		chk_edges_next = chk_edges_reg;
		chk_clean_next = chk_clean_reg;
		if (conv_tick) begin
			chk_edges_next = 5'h00;
			chk_clean_next = 1'b1;
		end else if (ref_edge) begin
			chk_edges_next = chk_edges_reg + 5'h01;
		end
		if (wr_div_reg) begin
			chk_clean_next = 1'b0;
		end
	end

	// First interval after reset is left unchecked as well
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chk_edges_reg <= 5'h00;
			chk_clean_reg <= 1'b0;
		end else begin
			chk_edges_reg <= chk_edges_next;
			chk_clean_reg <= chk_clean_next;
		end
	end

	// A tick that ends a clean interval comes on the 4th or 16th reference edge
	a_div_count: assert property (@(posedge hclk) disable iff (!hresetn)
		(conv_tick && chk_clean_reg)
		|-> (chk_edges_reg == (div_sel_reg ? (`ADCRD_DIV_SLOW - 5'h01)
			: (`ADCRD_DIV_FAST - 5'h01))))
		else $error("converter clock divide ratio wrong");

	// Low halfword carries the sample and bits 30:16 read zero
	a_low_half: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_result |=> (hrdata[15:0] == $past(sample_reg)) && (hrdata[30:16] == 15'h0000))
		else $error("result word layout wrong");

	// Done clears at the start and sets, with the engine idle again, at the finish
	a_done_flow: assert property (@(posedge hclk) disable iff (!hresetn)
		(conv_start |=> !done_reg) and (conv_finish |=> done_reg && !adc_busy))
		else $error("done flag not cleared at start or set at finish");

endmodule // adcrd_top
`default_nettype wire

// File: tb/adcrd_top_tb_top.sv
// Testbench of the read-triggered converter control block
`timescale 1ns/1ns
`default_nettype none
`include "adcrd_cfg.svh"

module adcrd_top_tb_top;
	// ----------------------------------------
	// Stimulus signals and the design
	// ----------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ref_clk_in = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [15:0] adc_sample_in = 16'h0000;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic adc_busy;
	logic [31:0] r;
	int err_count = 0;
	int total_checks = 0;

	// Reference at a quarter of hclk, so each level spans two rising hclk edges
	always #10 hclk = ~hclk;
	always #40 ref_clk_in = ~ref_clk_in;

	adcrd_top dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.ref_clk_in(ref_clk_in),
		.adc_sample_in(adc_sample_in),
		.adc_busy(adc_busy)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One single word transfer; entered and left just after a rising edge
	task automatic bus(input logic [3:0] ofs, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {28'h0000000, ofs};
		htrans <= `ADCRD_HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		check({hrdata[31:1], adc_busy}, 32'h00000000);
		check({31'h00000000, hresp}, 32'h00000000);
		hresetn <= 1'b1;
		bus(`ADCRD_OFS_DIV, 1'b0, 32'h00000000, r);
		check(r, 32'h00000000);
		bus(4'hC, 1'b1, 32'hFFFFFFFF, r);
		bus(4'hC, 1'b0, 32'h00000000, r);
		check(r, 32'h00000000);
		bus(`ADCRD_OFS_RESULT, 1'b0, 32'h00000000, r);
		check(r & 32'h80000000, 32'h00000000);
		$display("test reset done");
	endtask

	// Wait-out, trigger, poke mid-conversion, time it, then fetch the sample
	task automatic run_conv(input logic [31:0] div_word, input int div,
		input logic [15:0] smp, input logic [15:0] exp);
		time t0;
		int n;
		int lo;
		lo = (`ADCRD_CONV_TICKS - 1) * div * 4;
		while (adc_busy === 1'b1) @(posedge hclk);
		adc_sample_in <= smp;
		bus(`ADCRD_OFS_DIV, 1'b1, div_word, r);
		bus(`ADCRD_OFS_DIV, 1'b0, 32'h00000000, r);
		check(r & 32'h00010001, div_word);
		bus(`ADCRD_OFS_RESULT, 1'b0, 32'h00000000, r);
		t0 = $time;
		check({31'h00000000, adc_busy}, 32'h00000001);
		bus(`ADCRD_OFS_STATUS, 1'b0, 32'h00000000, r);
		check(r, 32'h00000001);
		repeat (100) @(posedge hclk);
		bus(`ADCRD_OFS_RESULT, 1'b0, 32'h00000000, r);
		check(r & 32'h80000000, 32'h00000000);
		while (adc_busy === 1'b1) @(posedge hclk);
		n = int'(($time - t0) / 20);
		check((n >= lo && n <= lo + div * 4 + 12) ? lo : n, lo);
		bus(`ADCRD_OFS_STATUS, 1'b0, 32'h00000000, r);
		check(r, 32'h80000000);
		bus(`ADCRD_OFS_RESULT, 1'b0, 32'h00000000, r);
		check(r, {16'h8000, exp});
		if (div_word[`ADCRD_SIGNED_BIT]) begin
			check({{16{r[15]}}, r[15:0]}, {{16{exp[15]}}, exp});
		end
		$display("test conversion div %0d done", div);
	endtask

	initial begin
		repeat (20) @(posedge hclk);
		test_reset();
		run_conv(32'h00000000, 4, 16'hA5C3, 16'hA5C3);
		run_conv(32'h00010001, 16, 16'h1234, 16'h9234);
		run_conv(32'h00000001, 4, 16'h8001, 16'h0001);
		final_report();
	end

	// Watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		final_report();
	end
endmodule // adcrd_top_tb_top

`default_nettype wire
